//--- core/temp_mon_pkg.sv
// Shared constants, types and helper functions of the temperature monitor register block.
package temp_mon_pkg;
  localparam int TEMP_W = 11;
  localparam int CHAN_N = 5;
  // Byte register addresses.
  localparam logic [7:0] ADDR_INT_HI = 8'h00;
  localparam logic [7:0] ADDR_INT_LO = 8'h23;
  localparam logic [7:0] ADDR_EXT1_HI = 8'h01;
  localparam logic [7:0] ADDR_EXT1_LO = 8'h10;
  localparam logic [7:0] ADDR_EXT2_HI = 8'hf8;
  localparam logic [7:0] ADDR_EXT2_LO = 8'hf9;
  localparam logic [7:0] ADDR_EXT1X_HI = 8'hfa;
  localparam logic [7:0] ADDR_EXT1X_LO = 8'hfb;
  localparam logic [7:0] ADDR_EXT2X_HI = 8'hfc;
  localparam logic [7:0] ADDR_EXT2X_LO = 8'hfd;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CFG_RD = 8'h03;
  localparam logic [7:0] ADDR_CFG_WR = 8'h09;
  localparam logic [7:0] ADDR_EXTENDED_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_ONESHOT = 8'h0f;
  // Reset values and writable bit masks.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h45;
  localparam logic [7:0] EXTENDED_CONFIG_RESET = 8'h08;
  localparam logic [7:0] ONESHOT_READ = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h47;
  localparam logic [7:0] EXTENDED_CONFIG_WMASK = 8'h0f;
  // Field positions.
  localparam int STS_BUSY_BIT = 7;
  localparam int STS_HOTTER_BIT = 4;
  localparam int STS_FAULT2_BIT = 1;
  localparam int STS_FAULT1_BIT = 0;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_RATE_LSB = 0;
  localparam int EXTENDED_CONFIG_DEPTH_BIT = 3;
  localparam int EXTENDED_CONFIG_AVGDIS_BIT = 2;
  localparam int EXTENDED_CONFIG_PAIR_BIT = 1;
  localparam int EXTENDED_CONFIG_RFIX_BIT = 0;
  // Conversion rate codes and averaging codes.
  localparam logic [2:0] RATE_1 = 3'h3;
  localparam logic [2:0] RATE_8 = 3'h6;
  localparam logic [2:0] RATE_16 = 3'h7;
  localparam logic [1:0] AVG_1X = 2'h0;
  localparam logic [1:0] AVG_2X = 2'h1;
  localparam logic [1:0] AVG_4X = 2'h2;
  // Timing: one period at sixteen conversions per second.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SIXTEENTH_PERIOD_NS = 62_500_000;
  localparam int SIXTEENTH_CYCLES = SIXTEENTH_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

  function automatic logic [7:0] hi_byte(input logic [TEMP_W-1:0] w);
    hi_byte = w[10:3];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [TEMP_W-1:0] w);
    lo_byte = {w[2:0], 5'h00};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_INT_HI) || (a == ADDR_INT_LO) || (a == ADDR_EXT1_HI) ||
      (a == ADDR_EXT1_LO) || (a == ADDR_EXT2_HI) || (a == ADDR_EXT2_LO) ||
      (a == ADDR_EXT1X_HI) || (a == ADDR_EXT1X_LO) || (a == ADDR_EXT2X_HI) ||
      (a == ADDR_EXT2X_LO) || (a == ADDR_STATUS) || (a == ADDR_CFG_RD) ||
      (a == ADDR_EXTENDED_CONFIG) || (a == ADDR_ONESHOT);
  endfunction

  function automatic logic [1:0] avg_code(input logic depth, input logic dis,
                                          input logic [2:0] rate);
    if (dis || rate == RATE_16) begin
      avg_code = AVG_1X;
    end else if (!depth || rate == RATE_8) begin
      avg_code = AVG_2X;
    end else begin
      avg_code = AVG_4X;
    end
  endfunction
endpackage

//--- core/event_cross.sv
// Toggle-based crossing of a one-cycle event from one clock domain to another.
`timescale 1ns/100ps
`default_nettype none
module event_cross (
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_pulse,
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_pulse
);
  typedef struct packed {
    logic toggle;
  } src_state_t;
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic pulse;
  } dst_state_t;
  src_state_t s, next_s;
  dst_state_t d, next_d;

  always_comb begin
    next_s = s;
    next_s.toggle = s.toggle ^ src_pulse;
  end

  always_ff @(posedge src_clk or posedge src_rst) begin
    if (src_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Only the second and third stages are compared, the first stage feeds nothing else.
  always_comb begin
    next_d = d;
    next_d.meta = s.toggle;
    next_d.sync = d.meta;
    next_d.last = d.sync;
    next_d.pulse = d.sync ^ d.last;
  end

  always_ff @(posedge dst_clk or posedge dst_rst) begin
    if (dst_rst) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign dst_pulse = d.pulse;
endmodule // event_cross
`default_nettype wire

//--- core/rate_timer.sv
// Periodic conversion tick at the programmed rate while the monitor runs.
`timescale 1ns/100ps
`default_nettype none
module rate_timer #(
  parameter int unsigned BASE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic tick
);
  import temp_mon_pkg::*;
  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } timer_state_t;
  timer_state_t st, next_st;
  logic [2:0] shift;
  logic [31:0] period;

  always_comb begin
    // Reserved codes run at the slowest rate.
    shift = (rate_sel < RATE_1) ? 3'h4 : 3'(RATE_16 - rate_sel);
    period = 32'(BASE_CYCLES) << shift;
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.count = '0;
    end else if (st.count >= period - 32'h1) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 32'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // rate_timer
`default_nettype wire

//--- core/temp_monitor_regs.sv
// Register file and conversion sequencing of the remote-diode temperature monitor.
// How it works
// - Results are 11 bits, left aligned: high byte whole degrees, low byte fraction.
// - Extended result registers exist only for both external diodes, two bytes each.
// - Status at 02h is read-only, resets to 00h, writes change nothing.
// - A diode fault sets its status bit and leaves that channel's data alone.
// - Status bit 7 is high exactly while a conversion is under way.
// - Bit 4 shows diode 2 strictly hotter in pairwise mode, else reads 0.
// - Main configuration reads at 03h, writes at 09h, resets to 45h.
// - Configuration bit 6 low runs conversions at the rate; high means standby.
// - Rate field codes three to seven give one to sixteen conversions a second.
// - Second configuration register at 04h, read/write, resets to 08h.
// - Depth bit picks averaging: 1x at sixteen, 2x, then 4x below eight.
// - Averaging disable bit fixes external averaging at 1x for every rate.
// - Pairwise mode writes the hotter external result into the diode 2 registers.
// - Bit 0 enables line resistance correction on the diode 2 channel.
// - Any write to 0Fh starts one conversion; the data is dropped.
// - Reads of 0Fh always return 00h.
// - Reading a high result byte latches its low byte for the next read.
// - Undefined addresses read 00h and ignore writes.
// - Reset loads every register with its default value.
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_regs #(
  parameter int unsigned SIXTEENTH_PERIOD_CYCLES = temp_mon_pkg::SIXTEENTH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic conv_clk,
  output logic adc_start,
  output logic [1:0] adc_avg_code,
  output logic adc_res_fix_en,
  output logic adc_pairwise,
  input wire logic adc_done,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] adc_int_temp,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] adc_ext1_temp,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] adc_ext2_temp,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] adc_ext1_xtemp,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] adc_ext2_xtemp,
  input wire logic adc_ext1_fault,
  input wire logic adc_ext2_fault
);
  import temp_mon_pkg::*;

  typedef struct packed {
    seq_state_t state;
    logic [7:0] cfg;
    logic [7:0] extended_config;
    logic busy;
    logic pending;
    logic start_req;
    logic fault1;
    logic fault2;
    logic hotter;
    logic [TEMP_W-1:0] int_t;
    logic [TEMP_W-1:0] e1;
    logic [TEMP_W-1:0] e2;
    logic [TEMP_W-1:0] e1x;
    logic [TEMP_W-1:0] e2x;
    logic [CHAN_N-1:0][7:0] shadow;
    logic [7:0] rdata;
    logic [1:0] snap_avg;
    logic snap_rfix;
    logic snap_pair;
  } main_state_t;

  typedef struct packed {
    logic waiting;
    logic start;
    logic done_req;
    logic [1:0] avg;
    logic rfix;
    logic pair;
    logic [TEMP_W-1:0] int_t;
    logic [TEMP_W-1:0] e1;
    logic [TEMP_W-1:0] e2;
    logic [TEMP_W-1:0] e1x;
    logic [TEMP_W-1:0] e2x;
    logic f1;
    logic f2;
  } conv_state_t;

  main_state_t st, next_st;
  conv_state_t cv, next_cv;
  logic tick;
  logic start_evt;
  logic done_evt;
  logic run_mode;
  logic both_ok;
  logic wr_oneshot;

  assign run_mode = !st.cfg[CFG_STANDBY_BIT];

  rate_timer #(
    .BASE_CYCLES(SIXTEENTH_PERIOD_CYCLES)
  ) u_rate_timer (
    .clk(clk),
    .rst(rst),
    .run(run_mode),
    .rate_sel(st.cfg[CFG_RATE_LSB +: 3]),
    .tick(tick)
  );

  event_cross u_start_cross (
    .src_clk(clk),
    .src_rst(rst),
    .src_pulse(st.start_req),
    .dst_clk(conv_clk),
    .dst_rst(rst),
    .dst_pulse(start_evt)
  );

  event_cross u_done_cross (
    .src_clk(conv_clk),
    .src_rst(rst),
    .src_pulse(cv.done_req),
    .dst_clk(clk),
    .dst_rst(rst),
    .dst_pulse(done_evt)
  );

  // Converter side: config snapshot is held by the main side until done, results
  // are held here until the next start, so both words cross stable.
  always_comb begin
    next_cv = cv;
    next_cv.start = 1'b0;
    next_cv.done_req = 1'b0;
    if (start_evt) begin
      next_cv.start = 1'b1;
      next_cv.waiting = 1'b1;
      next_cv.avg = st.snap_avg;
      next_cv.rfix = st.snap_rfix;
      next_cv.pair = st.snap_pair;
    end else if (cv.waiting && adc_done) begin
      next_cv.waiting = 1'b0;
      next_cv.done_req = 1'b1;
      next_cv.int_t = adc_int_temp;
      next_cv.e1 = adc_ext1_temp;
      next_cv.e2 = adc_ext2_temp;
      next_cv.e1x = adc_ext1_xtemp;
      next_cv.e2x = adc_ext2_xtemp;
      next_cv.f1 = adc_ext1_fault;
      next_cv.f2 = adc_ext2_fault;
    end
  end

  always_ff @(posedge conv_clk or posedge rst) begin
    if (rst) begin
      cv <= '0;
    end else begin
      cv <= next_cv;
    end
  end

  assign both_ok = !cv.f1 && !cv.f2;
  assign wr_oneshot = reg_wr && reg_addr == ADDR_ONESHOT;

  always_comb begin
    next_st = st;
    next_st.start_req = 1'b0;
    // Register writes; status and undefined addresses fall through untouched.
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CFG_WR: next_st.cfg = reg_wdata & CFG_WMASK;
        ADDR_EXTENDED_CONFIG: next_st.extended_config = reg_wdata & EXTENDED_CONFIG_WMASK;
        default: next_st.cfg = st.cfg;
      endcase
    end
    // Register reads, answered one cycle later.
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_INT_HI: begin
          next_st.rdata = hi_byte(st.int_t);
          next_st.shadow[0] = lo_byte(st.int_t);
        end
        ADDR_EXT1_HI: begin
          next_st.rdata = hi_byte(st.e1);
          next_st.shadow[1] = lo_byte(st.e1);
        end
        ADDR_EXT2_HI: begin
          next_st.rdata = hi_byte(st.e2);
          next_st.shadow[2] = lo_byte(st.e2);
        end
        ADDR_EXT1X_HI: begin
          next_st.rdata = hi_byte(st.e1x);
          next_st.shadow[3] = lo_byte(st.e1x);
        end
        ADDR_EXT2X_HI: begin
          next_st.rdata = hi_byte(st.e2x);
          next_st.shadow[4] = lo_byte(st.e2x);
        end
        ADDR_INT_LO: next_st.rdata = st.shadow[0];
        ADDR_EXT1_LO: next_st.rdata = st.shadow[1];
        ADDR_EXT2_LO: next_st.rdata = st.shadow[2];
        ADDR_EXT1X_LO: next_st.rdata = st.shadow[3];
        ADDR_EXT2X_LO: next_st.rdata = st.shadow[4];
        ADDR_STATUS: begin
          next_st.rdata = STATUS_RESET;
          next_st.rdata[STS_BUSY_BIT] = st.busy;
          next_st.rdata[STS_HOTTER_BIT] = st.hotter && st.extended_config[EXTENDED_CONFIG_PAIR_BIT];
          next_st.rdata[STS_FAULT2_BIT] = st.fault2;
          next_st.rdata[STS_FAULT1_BIT] = st.fault1;
        end
        ADDR_CFG_RD: next_st.rdata = st.cfg;
        ADDR_EXTENDED_CONFIG: next_st.rdata = st.extended_config;
        ADDR_ONESHOT: next_st.rdata = ONESHOT_READ;
        default: next_st.rdata = UNMAPPED_READ;
      endcase
    end
    // Conversion sequencing.
    unique case (st.state)
      ST_IDLE: begin
        if (st.pending || (tick && run_mode)) begin
          next_st.state = ST_CONV;
          next_st.busy = 1'b1;
          next_st.pending = 1'b0;
          next_st.start_req = 1'b1;
          next_st.snap_avg = avg_code(st.extended_config[EXTENDED_CONFIG_DEPTH_BIT], st.extended_config[EXTENDED_CONFIG_AVGDIS_BIT],
            st.cfg[CFG_RATE_LSB +: 3]);
          next_st.snap_rfix = st.extended_config[EXTENDED_CONFIG_RFIX_BIT];
          next_st.snap_pair = st.extended_config[EXTENDED_CONFIG_PAIR_BIT];
        end
      end
      ST_CONV: begin
        if (done_evt) begin
          next_st.state = ST_IDLE;
          next_st.busy = 1'b0;
          next_st.int_t = cv.int_t;
          next_st.fault1 = cv.f1;
          next_st.fault2 = cv.f2;
          if (!cv.f1) begin
            next_st.e1 = cv.e1;
            next_st.e1x = cv.e1x;
          end
          if (st.snap_pair) begin
            next_st.hotter = both_ok && (cv.e2 > cv.e1);
            if (both_ok) begin
              next_st.e2 = (cv.e2 > cv.e1) ? cv.e2 : cv.e1;
              next_st.e2x = (cv.e2 > cv.e1) ? cv.e2x : cv.e1x;
            end
          end else if (!cv.f2) begin
            next_st.hotter = 1'b0;
            next_st.e2 = cv.e2;
            next_st.e2x = cv.e2x;
          end
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.busy = 1'b0;
      end
    endcase
    // A one-shot arriving while a start clears the request still counts.
    if (wr_oneshot) begin
      next_st.pending = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.cfg <= CFG_RESET;
      st.extended_config <= EXTENDED_CONFIG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign adc_start = cv.start;
  assign adc_avg_code = cv.avg;
  assign adc_res_fix_en = cv.rfix;
  assign adc_pairwise = cv.pair;

  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence cfg_write_s;
    reg_wr && !reg_rd && reg_addr == ADDR_CFG_WR;
  endsequence
  sequence cfg_read_s;
    reg_rd && !reg_wr && reg_addr == ADDR_CFG_RD;
  endsequence
  sequence ext1_high_read_s;
    reg_rd && !reg_wr && reg_addr == ADDR_EXT1_HI;
  endsequence
  sequence ext1_low_read_s;
    reg_rd && reg_addr == ADDR_EXT1_LO;
  endsequence

  chk_cfg_readback: assert property (
    cfg_write_s ##1 !reg_wr ##1 cfg_read_s |=> reg_rdata == ($past(reg_wdata, 3) & CFG_WMASK))
    else $error("configuration readback mismatch");
  chk_oneshot_read_zero: assert property (
    reg_rd && reg_addr == ADDR_ONESHOT |=> reg_rdata == 8'h00)
    else $error("one-shot address did not read zero");
  chk_unmapped_read_zero: assert property (
    reg_rd && !is_mapped(reg_addr) |=> reg_rdata == 8'h00)
    else $error("undefined address did not read zero");
  chk_busy_in_status: assert property (
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[STS_BUSY_BIT] == $past(st.busy))
    else $error("status busy bit disagrees with busy");
  chk_hotter_gated: assert property (
    reg_rd && reg_addr == ADDR_STATUS && !st.extended_config[EXTENDED_CONFIG_PAIR_BIT] |=>
      !reg_rdata[STS_HOTTER_BIT])
    else $error("hotter bit set outside pairwise mode");
  chk_standby_quiet: assert property (
    st.state == ST_IDLE && st.cfg[CFG_STANDBY_BIT] && !st.pending && !wr_oneshot
      |=> !st.busy)
    else $error("conversion started in standby");
  chk_oneshot_starts: assert property (
    wr_oneshot && st.state == ST_IDLE |-> ##[1:2] st.busy)
    else $error("one-shot did not start a conversion");
  chk_status_unwritable: assert property (
    reg_wr && reg_addr == ADDR_STATUS && !done_evt |=>
      $stable(st.fault1) && $stable(st.fault2) && $stable(st.hotter))
    else $error("status changed by a write");
  chk_fault_keeps_data: assert property (
    st.state == ST_CONV && done_evt && cv.f1 |=> $stable(st.e1) && st.fault1)
    else $error("faulted diode 1 data changed");
  chk_low_interlock: assert property (
    ext1_high_read_s ##1 (!reg_rd) [*2] ##1 ext1_low_read_s
      |=> reg_rdata == lo_byte($past(st.e1, 4)))
    else $error("low byte not coherent with high byte");
  chk_status_reserved: assert property (
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[6:5] == 2'h0 && reg_rdata[3:2] == 2'h0)
    else $error("reserved status bits not zero");
  chk_fault2_keeps_data: assert property (
    st.state == ST_CONV && done_evt && cv.f2 && !st.snap_pair |=> $stable(st.e2) && st.fault2)
    else $error("faulted diode 2 data changed");
  chk_oneshot_unstored: assert property (
    wr_oneshot |=> $stable(st.cfg) && $stable(st.extended_config))
    else $error("one-shot write changed a configuration register");
endmodule // temp_monitor_regs
`default_nettype wire

//--- sim/conv_model.sv
// Behavioural converter model answering each conversion start after a set delay.
`timescale 1ns/100ps
`default_nettype none
module conv_model (
  input wire logic conv_clk,
  input wire logic rst,
  input wire logic adc_start,
  input wire logic [7:0] dly,
  input wire logic [10:0] v_int,
  input wire logic [10:0] v_e1,
  input wire logic [10:0] v_e2,
  input wire logic [10:0] v_x1,
  input wire logic [10:0] v_x2,
  input wire logic v_f1,
  input wire logic v_f2,
  output logic adc_done,
  output logic [10:0] t_int,
  output logic [10:0] t_e1,
  output logic [10:0] t_e2,
  output logic [10:0] t_x1,
  output logic [10:0] t_x2,
  output logic f1,
  output logic f2,
  output logic [7:0] starts
);
  logic [7:0] cnt;
  logic busy;
  always_ff @(posedge conv_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      adc_done <= 1'b0;
      starts <= 8'h00;
    end else begin
      adc_done <= 1'b0;
      if (adc_start) begin
        busy <= 1'b1;
        cnt <= dly;
        starts <= starts + 8'h01;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // Outside the done pulse the results show their inverse, so a late sample fails.
  assign t_int = adc_done ? v_int : ~v_int;
  assign t_e1 = adc_done ? v_e1 : ~v_e1;
  assign t_e2 = adc_done ? v_e2 : ~v_e2;
  assign t_x1 = adc_done ? v_x1 : ~v_x1;
  assign t_x2 = adc_done ? v_x2 : ~v_x2;
  assign f1 = adc_done ? v_f1 : ~v_f1;
  assign f2 = adc_done ? v_f2 : ~v_f2;
endmodule // conv_model
`default_nettype wire

//--- sim/temp_monitor_regs_test.sv
// Self-checking bench of the temperature monitor register block.
`timescale 1ns/100ps
`default_nettype none
module temp_monitor_regs_test;
  import temp_mon_pkg::*;
  logic clk, rst, conv_clk, reg_wr, reg_rd, adc_start, adc_res_fix_en, adc_pairwise;
  logic adc_done, f1, f2, v_f1, v_f2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, dly, seen, starts, n0;
  logic [1:0] adc_avg_code;
  logic [TEMP_W-1:0] t_int, t_e1, t_e2, t_x1, t_x2, v_int, v_e1, v_e2, v_x1, v_x2;
  int n_fail, check_count;
  temp_monitor_regs #(.SIXTEENTH_PERIOD_CYCLES(20)) i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_clk(conv_clk), .adc_start(adc_start),
    .adc_avg_code(adc_avg_code), .adc_res_fix_en(adc_res_fix_en),
    .adc_pairwise(adc_pairwise), .adc_done(adc_done), .adc_int_temp(t_int),
    .adc_ext1_temp(t_e1), .adc_ext2_temp(t_e2), .adc_ext1_xtemp(t_x1),
    .adc_ext2_xtemp(t_x2), .adc_ext1_fault(f1), .adc_ext2_fault(f2));
  conv_model i_conv (
    .conv_clk(conv_clk), .rst(rst), .adc_start(adc_start), .dly(dly), .v_int(v_int),
    .v_e1(v_e1), .v_e2(v_e2), .v_x1(v_x1), .v_x2(v_x2), .v_f1(v_f1), .v_f2(v_f2),
    .adc_done(adc_done), .t_int(t_int), .t_e1(t_e1), .t_e2(t_e2), .t_x1(t_x1),
    .t_x2(t_x2), .f1(f1), .f2(f2), .starts(starts));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    conv_clk = 1'b0;
    #7;
    forever #24 conv_clk = ~conv_clk;
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    seen = reg_rdata;
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(what, seen, exp);
  endtask
  task automatic pair(input string what, input logic [7:0] ah, input logic [7:0] al,
                      input logic [10:0] t);
    rc(what, ah, t[10:3]);
    rc(what, al, {t[2:0], 5'h00});
  endtask
  task automatic load(input logic [10:0] a, input logic [10:0] b, input logic [10:0] c,
                      input logic g1, input logic g2);
    v_int = a;
    v_e1 = b;
    v_e2 = c;
    v_x1 = b ^ 11'h155;
    v_x2 = c ^ 11'h2aa;
    v_f1 = g1;
    v_f2 = g2;
  endtask
  // Starts a one-shot and polls busy until it has been seen high and then low.
  task automatic one_shot();
    logic hit;
    hit = 1'b0;
    wr(ADDR_ONESHOT, 8'h5a);
    for (int i = 0; i < 60; i++) begin
      rd(ADDR_STATUS);
      if (seen[STS_BUSY_BIT] === 1'b1) hit = 1'b1;
      if (hit && seen[STS_BUSY_BIT] === 1'b0) break;
    end
    check("busy high then low", {7'h00, hit && seen[7] === 1'b0}, 8'h01);
  endtask
  function automatic logic [7:0] exp_avg(input int d, input int r);
    if (d[0] || r == 7) return 8'h00;
    if (r == 6 || !d[1]) return 8'h01;
    return 8'h02;
  endfunction
  task automatic count_starts(input int cycles, input logic [7:0] lo, input logic [7:0] hi);
    n0 = starts;
    repeat (cycles) @(negedge clk);
    seen = starts - n0;
    check("start count", {7'h00, seen >= lo && seen <= hi}, 8'h01);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dly = 8'd10;
    load(11'h000, 11'h000, 11'h000, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rc("status", ADDR_STATUS, 8'h00);
    rc("config", ADDR_CFG_RD, 8'h45);
    rc("config 2", ADDR_EXTENDED_CONFIG, 8'h08);
    rc("unmapped", 8'h05, 8'h00);
    pair("ext2 extended", ADDR_EXT2X_HI, ADDR_EXT2X_LO, 11'h000);
    wr(ADDR_STATUS, 8'hff);
    rc("status", ADDR_STATUS, 8'h00);
    wr(ADDR_CFG_RD, 8'h00);
    rc("config", ADDR_CFG_RD, 8'h45);
    wr(8'h05, 8'hff);
    rc("unmapped", 8'h05, 8'h00);
    wr(ADDR_CFG_WR, 8'hff);
    rc("config", ADDR_CFG_RD, 8'h47);
    wr(ADDR_CFG_WR, 8'h45);
    load(11'h1ff, 11'h5a3, 11'h3c5, 1'b0, 1'b0);
    one_shot();
    rc("one-shot read", ADDR_ONESHOT, 8'h00);
    check("averaging", {6'h00, adc_avg_code}, 8'h02);
    pair("internal", ADDR_INT_HI, ADDR_INT_LO, 11'h1ff);
    pair("ext1", ADDR_EXT1_HI, ADDR_EXT1_LO, 11'h5a3);
    pair("ext2", ADDR_EXT2_HI, ADDR_EXT2_LO, 11'h3c5);
    pair("ext1 extended", ADDR_EXT1X_HI, ADDR_EXT1X_LO, 11'h5a3 ^ 11'h155);
    pair("ext2 extended", ADDR_EXT2X_HI, ADDR_EXT2X_LO, 11'h3c5 ^ 11'h2aa);
    count_starts(400, 8'd0, 8'd0);
    rd(ADDR_EXT1_HI);
    load(11'h1ff, 11'h7fe, 11'h3c5, 1'b0, 1'b0);
    one_shot();
    rc("ext1 low latched", ADDR_EXT1_LO, 8'h60);
    pair("ext1", ADDR_EXT1_HI, ADDR_EXT1_LO, 11'h7fe);
    for (int d = 0; d < 4; d++) begin
      for (int r = 3; r < 8; r++) begin
        wr(ADDR_EXTENDED_CONFIG, {4'h0, 2'(d), 2'(d)});
        wr(ADDR_CFG_WR, 8'h40 | 8'(r));
        one_shot();
        check("averaging", {6'h00, adc_avg_code}, exp_avg(d, r));
        check("mode levels", {6'h00, adc_pairwise, adc_res_fix_en}, 8'(d));
      end
    end
    wr(ADDR_EXTENDED_CONFIG, 8'h02);
    load(11'h100, 11'h200, 11'h300, 1'b0, 1'b0);
    one_shot();
    rc("status hotter", ADDR_STATUS, 8'h10);
    pair("ext2 hotter", ADDR_EXT2_HI, ADDR_EXT2_LO, 11'h300);
    load(11'h111, 11'h500, 11'h250, 1'b0, 1'b0);
    one_shot();
    rc("status hotter", ADDR_STATUS, 8'h00);
    pair("ext2 hotter", ADDR_EXT2_HI, ADDR_EXT2_LO, 11'h500);
    pair("ext1", ADDR_EXT1_HI, ADDR_EXT1_LO, 11'h500);
    pair("internal", ADDR_INT_HI, ADDR_INT_LO, 11'h111);
    load(11'h111, 11'h333, 11'h333, 1'b0, 1'b0);
    one_shot();
    rc("status equal", ADDR_STATUS, 8'h00);
    load(11'h100, 11'h200, 11'h300, 1'b0, 1'b0);
    one_shot();
    wr(ADDR_EXTENDED_CONFIG, 8'h00);
    rc("status normal", ADDR_STATUS, 8'h00);
    load(11'h0aa, 11'h7ff, 11'h000, 1'b1, 1'b0);
    one_shot();
    rc("status fault", ADDR_STATUS, 8'h01);
    pair("ext1 kept", ADDR_EXT1_HI, ADDR_EXT1_LO, 11'h200);
    pair("ext2", ADDR_EXT2_HI, ADDR_EXT2_LO, 11'h000);
    load(11'h0aa, 11'h123, 11'h7ff, 1'b0, 1'b1);
    one_shot();
    rc("status fault", ADDR_STATUS, 8'h02);
    pair("ext2 kept", ADDR_EXT2_HI, ADDR_EXT2_LO, 11'h000);
    pair("ext1", ADDR_EXT1_HI, ADDR_EXT1_LO, 11'h123);
    dly = 8'd1;
    wr(ADDR_CFG_WR, 8'h07);
    count_starts(200, 8'd9, 8'd11);
    wr(ADDR_CFG_WR, 8'h03);
    count_starts(700, 8'd2, 8'd3);
    wr(ADDR_CFG_WR, 8'h45);
    repeat (40) @(negedge clk);
    count_starts(400, 8'd0, 8'd0);
    conclude();
  end
endmodule // temp_monitor_regs_test
`default_nettype wire
